// [hw/eadb_master.sv]
`timescale 1ns/1ps
`include "eadb_defs.svh"

module eadb_master (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // request side
    input  wire logic        req,
    input  wire logic        req_read,
    input  wire logic [31:0] req_addr,
    input  wire logic [3:0]  req_fc,
    input  wire logic [2:0]  req_bytes,
    input  wire logic [31:0] req_wdata,
    output logic             busy_r,
    output logic             done_r,
    output logic [31:0]      rdata_r,
    output logic [2:0]       ack_width_r,
    // upper pin configuration
    input  wire logic [15:0] pin_mode,
    input  wire logic [7:0]  port_out,
    input  wire logic [7:0]  port_oe,
    output logic [7:0]       port_in_r,
    // bus pins
    output logic [23:0]      low_address_lines_r,
    output logic             low_address_oe_r,
    output logic [7:0]       upper_address_byte_r,
    output logic [7:0]       upper_address_oe_r,
    input  wire logic [7:0]  upper_address_in,
    output logic [31:0]      data_lines_out_r,
    output logic             data_lines_oe_r,
    input  wire logic [31:0] data_lines_in,
    output logic             address_valid_strobe_b_r,
    output logic             data_strobe_b_r,
    output logic             rd_wr_r,
    output logic [1:0]       remaining_bytes_code_r,
    output logic [3:0]       func_code_r,
    input  wire logic [1:0]  width_ack_pair_b
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0]  ack_s1_r, ack_s2_r;
    logic [7:0]  up_s1_r;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ack_s1_r  <= `EADB_ACK_WAIT;
            ack_s2_r  <= `EADB_ACK_WAIT;
            up_s1_r   <= 8'h00;
            port_in_r <= 8'h00;
        end else begin
            ack_s1_r  <= width_ack_pair_b;
            ack_s2_r  <= ack_s1_r;
            up_s1_r   <= upper_address_in;
            port_in_r <= up_s1_r;
        end
    end

    // ------------------------------------------------------------
    // cycle state
    // ------------------------------------------------------------
    eadb_pkg::eadb_state_t state_r;
    logic [31:0] addr_r;
    logic [3:0]  fc_r;
    logic        rd_r;
    logic [31:0] wdata_r;
    logic [2:0]  bytes_r;
    logic        ack_seen;
    logic        is_iack;
    logic [2:0]  iack_lvl;

    assign ack_seen = (ack_s2_r != `EADB_ACK_WAIT);
    assign is_iack  = (fc_r == `EADB_FC_CPU) &&
                      (addr_r[`EADB_IACK_TYPE_LSB +: 4] == `EADB_IACK_TYPE);
    assign iack_lvl = addr_r[`EADB_IACK_LVL_LSB +: 3];

    function automatic logic [2:0] ack_bytes(input logic [1:0] ack_b);
        unique case (ack_b)
            `EADB_ACK_8:  ack_bytes = 3'h1;
            `EADB_ACK_16: ack_bytes = 3'h2;
            default:      ack_bytes = 3'h4;
        endcase
    endfunction

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r <= eadb_pkg::EADB_IDLE;
            addr_r  <= 32'h0000_0000;
            fc_r    <= 4'h0;
            rd_r    <= 1'b1;
            wdata_r <= 32'h0000_0000;
            bytes_r <= 3'h0;
        end else begin
            unique case (state_r)
                eadb_pkg::EADB_IDLE: begin
                    if (req) begin
                        addr_r  <= req_addr;
                        fc_r    <= req_fc;
                        rd_r    <= req_read;
                        wdata_r <= req_wdata;
                        bytes_r <= (req_bytes == 3'h0) ? 3'h4 : req_bytes;
                        state_r <= eadb_pkg::EADB_ADDR;
                    end
                end
                eadb_pkg::EADB_ADDR: state_r <= eadb_pkg::EADB_DATA;
                eadb_pkg::EADB_DATA: state_r <= eadb_pkg::EADB_WAIT;
                eadb_pkg::EADB_WAIT: begin
                    if (ack_seen) begin
                        state_r <= eadb_pkg::EADB_DONE;
                    end
                end
                eadb_pkg::EADB_DONE: state_r <= eadb_pkg::EADB_IDLE;
                default: state_r <= eadb_pkg::EADB_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // strobes, direction, size, address
    // ------------------------------------------------------------
    logic in_cycle, as_on, ds_on;
    logic [1:0] size_now;
    assign in_cycle = (state_r != eadb_pkg::EADB_IDLE);
    assign as_on = (state_r == eadb_pkg::EADB_DATA) || (state_r == eadb_pkg::EADB_WAIT);
    assign ds_on = rd_r ? as_on : (state_r == eadb_pkg::EADB_WAIT);

    eadb_size_calc u_size (
        .remain    (bytes_r),
        .size_code (size_now)
    );

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            address_valid_strobe_b_r <= 1'b1;
            data_strobe_b_r          <= 1'b1;
            rd_wr_r                  <= 1'b1;
            remaining_bytes_code_r   <= `EADB_SIZE_LONG;
            func_code_r              <= 4'h0;
            low_address_lines_r      <= 24'h00_0000;
            low_address_oe_r         <= 1'b0;
        end else begin
            address_valid_strobe_b_r <= !as_on;
            data_strobe_b_r          <= !ds_on;
            rd_wr_r                  <= in_cycle ? rd_r : 1'b1;
            remaining_bytes_code_r   <= size_now;
            func_code_r              <= fc_r;
            low_address_lines_r      <= addr_r[23:0];
            low_address_oe_r         <= in_cycle && !is_iack;
        end
    end

    // ------------------------------------------------------------
    // upper pins: address, port or level acknowledge
    // ------------------------------------------------------------
    logic [7:0] iack_b, up_out, up_oe;
    always_comb begin
        iack_b = 8'hFF;
        if (in_cycle && is_iack && (iack_lvl != 3'h0)) begin
            iack_b[iack_lvl] = 1'b0;
        end
    end

    eadb_upper_mux u_upper (
        .pin_mode   (pin_mode),
        .addr_hi    (addr_r[31:24]),
        .port_out   (port_out),
        .port_oe    (port_oe),
        .iack_lvl_b (iack_b),
        .drive_addr (in_cycle && !is_iack),
        .pin_out    (up_out),
        .pin_oe     (up_oe)
    );

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            upper_address_byte_r <= 8'hFF;
            upper_address_oe_r   <= 8'h00;
        end else begin
            upper_address_byte_r <= up_out;
            upper_address_oe_r   <= up_oe;
        end
    end

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            data_lines_out_r <= 32'h0000_0000;
            data_lines_oe_r  <= 1'b0;
        end else begin
            data_lines_out_r <= wdata_r;
            data_lines_oe_r  <= !rd_r && as_on;
        end
    end

    // capture on the falling edge of the terminating clock
    logic [31:0] rd_cap_r;
    always_ff @(negedge mclk) begin
        if (!rst_b) begin
            rd_cap_r <= 32'h0000_0000;
        end else if (state_r == eadb_pkg::EADB_DONE && rd_r) begin
            rd_cap_r <= data_lines_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            rdata_r     <= 32'h0000_0000;
            ack_width_r <= 3'h0;
        end else begin
            busy_r <= in_cycle || req;
            done_r <= (state_r == eadb_pkg::EADB_DONE);
            if (state_r == eadb_pkg::EADB_DONE) begin
                rdata_r <= rd_cap_r;
            end
            if (state_r == eadb_pkg::EADB_WAIT && ack_seen) begin
                ack_width_r <= ack_bytes(ack_s2_r);
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_addr_stable: assert property (@(posedge mclk) disable iff (!rst_b)
        !address_valid_strobe_b_r && $past(!address_valid_strobe_b_r)
        |-> $stable(low_address_lines_r))
        else $error("address moved while strobe asserted");
    a_write_ds_lag: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(address_valid_strobe_b_r) && !rd_wr_r |-> data_strobe_b_r ##1 !data_strobe_b_r)
        else $error("write data strobe not one clock late");
    a_read_ds_same: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(address_valid_strobe_b_r) && rd_wr_r |-> !data_strobe_b_r)
        else $error("read strobes not together");
    a_read_hiz: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_wr_r |-> !data_lines_oe_r)
        else $error("data driven during read");
    a_write_drive: assert property (@(posedge mclk) disable iff (!rst_b)
        !data_strobe_b_r && !rd_wr_r |-> data_lines_oe_r)
        else $error("write data not driven");
    a_iack_onehot: assert property (@(posedge mclk) disable iff (!rst_b)
        $onehot0(~iack_b))
        else $error("more than one level ack");
    a_size_code: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == eadb_pkg::EADB_DATA && bytes_r == 3'h1
        |=> remaining_bytes_code_r == `EADB_SIZE_BYTE)
        else $error("size code wrong for byte");
    a_dir_level: assert property (@(posedge mclk) disable iff (!rst_b)
        !address_valid_strobe_b_r |-> rd_wr_r == rd_r)
        else $error("direction wrong");
    a_ack_end: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == eadb_pkg::EADB_WAIT && ack_seen |-> ##2 done_r)
        else $error("cycle did not end after ack");
    a_low_oe_iack: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == eadb_pkg::EADB_DATA && is_iack |-> !low_address_oe_r)
        else $error("low address driven in cpu space");
    a_low_oe_drive: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == eadb_pkg::EADB_DATA && !is_iack |-> low_address_oe_r)
        else $error("low address not driven");
    a_iack_pin: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == eadb_pkg::EADB_WAIT && is_iack && iack_lvl != 3'h0 &&
        pin_mode[{iack_lvl, 1'b0} +: 2] == `EADB_PIN_IACK
        |-> !upper_address_byte_r[iack_lvl])
        else $error("level ack pin not asserted");
    a_write_data: assert property (@(posedge mclk) disable iff (!rst_b)
        !data_strobe_b_r && !rd_wr_r |-> data_lines_out_r == wdata_r)
        else $error("write data not on all lines");
    a_ctrl_stable: assert property (@(posedge mclk) disable iff (!rst_b)
        !address_valid_strobe_b_r && $past(!address_valid_strobe_b_r)
        |-> $stable(remaining_bytes_code_r) && $stable(rd_wr_r) && $stable(func_code_r))
        else $error("cycle controls moved while strobe asserted");
    a_ds_release: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(address_valid_strobe_b_r) |-> data_strobe_b_r)
        else $error("data strobe outlived address strobe");
    a_ds_inside_as: assert property (@(posedge mclk) disable iff (!rst_b)
        !data_strobe_b_r |-> !address_valid_strobe_b_r)
        else $error("data strobe without address strobe");
    a_ack_width: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == eadb_pkg::EADB_WAIT && ack_seen && ack_s2_r == `EADB_ACK_8
        |=> ack_width_r == 3'h1)
        else $error("byte port width not reported");

    // ------------------------------------------------------------
    // scenarios covered
    // ------------------------------------------------------------
    c_read: cover property (@(posedge mclk) disable iff (!rst_b) done_r && rd_wr_r);
    c_write: cover property (@(posedge mclk) disable iff (!rst_b) done_r && !rd_wr_r);
    c_iack: cover property (@(posedge mclk) disable iff (!rst_b) iack_b != 8'hFF);
    c_wait_state: cover property (@(posedge mclk) disable iff (!rst_b)
        state_r == eadb_pkg::EADB_WAIT ##1 state_r == eadb_pkg::EADB_WAIT);
    c_byte_port: cover property (@(posedge mclk) disable iff (!rst_b)
        done_r && ack_width_r == 3'h1);

endmodule

// [hw/eadb_defs.svh]
`ifndef EADB_DEFS_SVH
`define EADB_DEFS_SVH

// remaining_bytes_code encodings
`define EADB_SIZE_LONG      2'h0
`define EADB_SIZE_BYTE      2'h1
`define EADB_SIZE_WORD      2'h2
`define EADB_SIZE_THREE     2'h3

// width_ack_pair (active low: {ack1_b, ack0_b})
`define EADB_ACK_WAIT       2'h3
`define EADB_ACK_8          2'h2
`define EADB_ACK_16         2'h1
`define EADB_ACK_32         2'h0

// function code of the cpu space
`define EADB_FC_CPU         4'h7

// upper pin modes (2 bits per pin)
`define EADB_PIN_ADDR       2'h0
`define EADB_PIN_PORT       2'h1
`define EADB_PIN_IACK       2'h2

// interrupt-acknowledge level field inside a cpu-space address
`define EADB_IACK_LVL_LSB   1
`define EADB_IACK_TYPE_LSB  16
`define EADB_IACK_TYPE      4'hF

// reset value of the upper pin mode word: all address
`define EADB_PIN_MODE_RST   16'h0000

`endif

// [hw/eadb_pkg.sv]
package eadb_pkg;

    typedef enum logic [2:0] {
        EADB_IDLE  = 3'h0,
        EADB_ADDR  = 3'h1,
        EADB_DATA  = 3'h3,
        EADB_WAIT  = 3'h2,
        EADB_DONE  = 3'h6
    } eadb_state_t;

endpackage

// [hw/eadb_size_calc.sv]
`timescale 1ns/1ps
`include "eadb_defs.svh"

// remaining-bytes code from the count still to move
module eadb_size_calc (
    // count in
    input  wire logic [2:0] remain,
    // code out
    output logic      [1:0] size_code
);
    always_comb begin
        unique case (remain)
            3'h1:    size_code = `EADB_SIZE_BYTE;
            3'h2:    size_code = `EADB_SIZE_WORD;
            3'h3:    size_code = `EADB_SIZE_THREE;
            default: size_code = `EADB_SIZE_LONG;
        endcase
    end
endmodule

// [hw/eadb_upper_mux.sv]
`timescale 1ns/1ps
`include "eadb_defs.svh"

// per-pin selection of the upper address byte function
module eadb_upper_mux (
    // configuration
    input  wire logic [15:0] pin_mode,
    // sources
    input  wire logic [7:0]  addr_hi,
    input  wire logic [7:0]  port_out,
    input  wire logic [7:0]  port_oe,
    input  wire logic [7:0]  iack_lvl_b,
    input  wire logic        drive_addr,
    // pin side
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe
);
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            always_comb begin
                unique case (pin_mode[2*g +: 2])
                    `EADB_PIN_PORT: begin
                        pin_out[g] = port_out[g];
                        pin_oe[g]  = port_oe[g];
                    end
                    `EADB_PIN_IACK: begin
                        pin_out[g] = iack_lvl_b[g];
                        pin_oe[g]  = 1'b1;
                    end
                    default: begin
                        pin_out[g] = addr_hi[g];
                        pin_oe[g]  = drive_addr;
                    end
                endcase
            end
        end
    endgenerate
endmodule

// [sim/eadb_slave_model.sv]
`timescale 1ns/1ps
`include "eadb_defs.svh"

// ------------------------------------------------------------
// responding memory: acks after a set wait, drives read data
// ------------------------------------------------------------
module eadb_slave_model (
    // clock
    input  wire logic        mclk,
    // bus from master
    input  wire logic        as_b,
    input  wire logic        ds_b,
    input  wire logic        rd_wr,
    input  wire logic [31:0] addr,
    input  wire logic        low_oe,
    input  wire logic [1:0]  size,
    input  wire logic [31:0] wdata,
    input  wire logic        d_oe,
    // behaviour
    input  wire logic [1:0]  ack_code,
    input  wire logic [3:0]  ack_delay,
    input  wire logic [31:0] rd_value,
    // to master
    output logic      [1:0]  ack_b,
    output logic      [31:0] d_out,
    // observation
    output logic      [31:0] cap_addr,
    output logic      [31:0] cap_wdata,
    output logic      [1:0]  cap_size,
    output logic             cap_rw,
    output logic             cap_doe,
    output logic             cap_low_oe,
    output logic      [3:0]  cap_gap,
    output logic      [7:0]  moved
);
    logic [3:0]  wait_r = 4'h0;
    logic [3:0]  gap_r  = 4'h0;
    logic        ds_prev_r = 1'b1;
    logic        as_prev_r = 1'b1;
    logic [31:0] addr_prev_r;
    logic [31:0] d_r = 32'h0;

    initial moved = 8'h0;
    initial ack_b = `EADB_ACK_WAIT;
    assign d_out = d_r;

    always @(posedge mclk) begin
        if (as_b) begin
            wait_r <= 4'h0;
            ack_b  <= `EADB_ACK_WAIT;
        end else begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= ack_delay) ack_b <= ack_code;
        end
    end

    // released data lines toggle so stale values never look valid
    always_ff @(posedge mclk) begin
        if (!ds_b && rd_wr) d_r <= rd_value;
        else d_r <= ~d_r;
    end

    always @(posedge mclk) begin
        ds_prev_r   <= ds_b;
        as_prev_r   <= as_b;
        addr_prev_r <= addr;
        if (as_b) gap_r <= 4'h0;
        else if (ds_b) gap_r <= gap_r + 4'h1;
        if (!as_b && !as_prev_r && low_oe && addr != addr_prev_r) moved <= moved + 8'h1;
        if (!ds_b && ds_prev_r) begin
            cap_addr   <= addr;
            cap_wdata  <= wdata;
            cap_size   <= size;
            cap_rw     <= rd_wr;
            cap_doe    <= d_oe;
            cap_low_oe <= low_oe;
            cap_gap    <= gap_r;
        end
    end
endmodule

// [sim/external_address_data_bus_test.sv]
`timescale 1ns/1ps
`include "eadb_defs.svh"

module external_address_data_bus_test;
    typedef struct packed {
        logic        rd;
        logic        iack;
        logic [3:0]  fc;
        logic [31:0] addr;
        logic [1:0]  size;
        logic [31:0] data;
        logic [2:0]  width;
    } eadb_exp_t;

    logic        mclk = 1'b0;
    logic        rst_b, req, req_read, busy_r, done_r;
    logic [31:0] req_addr, req_wdata, rdata_r, data_lines_out_r, data_lines_in;
    logic [3:0]  req_fc, func_code_r, ack_delay, cap_gap;
    logic [2:0]  req_bytes, ack_width_r;
    logic [15:0] pin_mode;
    logic [7:0]  port_out, port_oe, port_in_r, upper_address_byte_r, upper_address_oe_r;
    logic [7:0]  upper_address_in, ext_port, moved;
    logic [23:0] low_address_lines_r;
    logic        low_address_oe_r, data_lines_oe_r, address_valid_strobe_b_r;
    logic        data_strobe_b_r, rd_wr_r, cap_rw, cap_doe, cap_low_oe;
    logic [1:0]  remaining_bytes_code_r, width_ack_pair_b, ack_code, cap_size;
    logic [31:0] rd_value, slave_d, cap_addr, cap_wdata;
    logic [31:0] seed = 32'h9DCE;
    int          n_mismatch = 0;
    int          checked = 0;
    eadb_exp_t   exp_q[$];
    eadb_exp_t   e;
    logic [1:0]  acks[3] = '{`EADB_ACK_8, `EADB_ACK_16, `EADB_ACK_32};

    always #25 mclk = ~mclk;

    // pins outside port drive come from the board
    assign upper_address_in = (upper_address_oe_r & upper_address_byte_r)
                            | (~upper_address_oe_r & ext_port);
    assign data_lines_in = data_lines_oe_r ? data_lines_out_r : slave_d;

    eadb_master DUT (.mclk, .rst_b, .req, .req_read, .req_addr, .req_fc, .req_bytes,
        .req_wdata, .busy_r, .done_r, .rdata_r, .ack_width_r, .pin_mode, .port_out,
        .port_oe, .port_in_r, .low_address_lines_r, .low_address_oe_r,
        .upper_address_byte_r, .upper_address_oe_r, .upper_address_in, .data_lines_out_r,
        .data_lines_oe_r, .data_lines_in, .address_valid_strobe_b_r, .data_strobe_b_r,
        .rd_wr_r, .remaining_bytes_code_r, .func_code_r, .width_ack_pair_b);

    eadb_slave_model slave (.mclk(mclk), .as_b(address_valid_strobe_b_r),
        .ds_b(data_strobe_b_r), .rd_wr(rd_wr_r),
        .addr({upper_address_byte_r, low_address_lines_r}), .low_oe(low_address_oe_r),
        .size(remaining_bytes_code_r), .wdata(data_lines_out_r), .d_oe(data_lines_oe_r),
        .ack_code(ack_code), .ack_delay(ack_delay), .rd_value(rd_value),
        .ack_b(width_ack_pair_b), .d_out(slave_d), .cap_addr(cap_addr),
        .cap_wdata(cap_wdata), .cap_size(cap_size), .cap_rw(cap_rw), .cap_doe(cap_doe),
        .cap_low_oe(cap_low_oe), .cap_gap(cap_gap), .moved(moved));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h0);
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic run(input logic rd, input logic [31:0] a, input logic [3:0] fc,
                       input logic [2:0] nb, input logic [1:0] ak);
        eadb_exp_t x;
        int        n;
        seed = lfsr(seed);
        @(negedge mclk);
        req_read  = rd;
        req_addr  = a;
        req_fc    = fc;
        req_bytes = nb;
        req_wdata = seed;
        rd_value  = ~seed;
        ack_code  = ak;
        ack_delay = seed[3:0] & 4'h3;
        req       = 1'b1;
        x.rd      = rd;
        x.iack    = (fc == `EADB_FC_CPU);
        x.fc      = fc;
        x.addr    = x.iack ? {~(8'h01 << a[3:1]), 24'h0} : a;
        x.size    = nb[1:0];
        x.data    = rd ? ~seed : seed;
        x.width   = (ak == `EADB_ACK_8) ? 3'h1 : (ak == `EADB_ACK_16) ? 3'h2 : 3'h4;
        exp_q.push_back(x);
        @(negedge mclk);
        req = 1'b0;
        n = 0;
        while (done_r !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 100) n_mismatch++;
    endtask

    // ------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------
    always @(negedge mclk) begin
        if (done_r === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e.iack) begin
                cmp(cap_addr[31:24], e.addr[31:24]);
                cmp(cap_low_oe, 32'h0);
            end else begin
                cmp(cap_addr, e.addr);
                cmp(cap_low_oe, 32'h1);
            end
            cmp(func_code_r, e.fc);
            cmp(cap_size, e.size);
            cmp(cap_rw, e.rd);
            cmp(cap_gap, {31'h0, ~e.rd});
            cmp(cap_doe, {31'h0, ~e.rd});
            cmp(e.rd ? rdata_r : cap_wdata, e.data);
            cmp(ack_width_r, e.width);
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {rst_b, req, req_read, req_addr, req_fc, req_bytes, req_wdata} = '0;
        {port_out, port_oe, ext_port, ack_delay, rd_value} = '0;
        pin_mode = `EADB_PIN_MODE_RST;
        ack_code = `EADB_ACK_32;
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        for (int i = 0; i < 24; i++) begin
            run(i[0], {seed[15:0], seed[31:16]}, 4'h5, 3'(i % 4) + 3'h1, acks[i % 3]);
        end
        pin_mode = 16'hAAAA;
        for (int l = 1; l < 8; l++) begin
            run(1'b1, {12'h0, 4'hF, 12'h0, 3'(l), 1'b0}, `EADB_FC_CPU, 3'h2, `EADB_ACK_16);
        end
        pin_mode = 16'h5555;
        port_out = seed[7:0];
        port_oe  = 8'hF0;
        ext_port = seed[15:8];
        repeat (4) @(negedge mclk);
        cmp(port_in_r, {port_out[7:4], ext_port[3:0]});
        cmp(upper_address_oe_r, port_oe);
        cmp(moved, 32'h0);
        repeat (4) @(negedge mclk);
        print_verdict();
    end
endmodule
